//--- bench/spct_timer_route_properties.sv
// concurrent checks on the ports of the compare timer and routing block
`timescale 1ns/1ps
module spct_timer_route_properties #(
   parameter int DIV_W = 16
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // avalon-mm slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // frame events and receive line
   input wire logic i_tx_frame_end,
   input wire logic i_tx_done,
   input wire logic i_tx_begin,
   input wire logic i_rx_frame_end,
   input wire logic i_rx_line,
   // timing lookup
   input wire logic [2:0] i_timing_code,
   input wire logic [8:0] o_timing_span,
   // comparator results
   input wire logic [2:0] o_match_event,
   input wire logic [2:0] o_match_flag,
   input wire logic o_timer_running,
   // pin enables and locations
   input wire logic o_receive_pin_enable,
   input wire logic o_transmit_pin_enable,
   input wire logic o_select_pin_enable,
   input wire logic o_serial_clock_pin_enable,
   input wire logic o_clear_pin_enable,
   input wire logic o_request_pin_enable,
   input wire logic [5:0] o_receive_location,
   input wire logic [5:0] o_transmit_location,
   input wire logic [5:0] o_select_location,
   input wire logic [5:0] o_serial_clock_location
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   // full-word write that completes at this edge
   sequence done_write(logic [7:0] addr);
      i_avs_write && !o_avs_waitrequest && i_avs_address == addr && i_avs_byteenable == 4'hF;
   endsequence
   one_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus request not answered after one wait state");
   idle_no_wait_a: assert property (!i_avs_read && !i_avs_write |-> !o_avs_waitrequest)
      else $error("waitrequest high with no request");
   data_pins_a: assert property (done_write(spct_pkg::OFS_PEN) |=>
      {o_transmit_pin_enable, o_receive_pin_enable} == $past(i_avs_writedata[1:0]))
      else $error("transmit or receive pin enable wrong");
   clock_select_a: assert property (done_write(spct_pkg::OFS_PEN) |=>
      {o_serial_clock_pin_enable, o_select_pin_enable} == $past(i_avs_writedata[3:2]))
      else $error("clock or select pin enable wrong");
   flow_pins_a: assert property (done_write(spct_pkg::OFS_PEN) |=>
      {o_request_pin_enable, o_clear_pin_enable} == $past(i_avs_writedata[5:4]))
      else $error("flow control pin enable wrong");
   location_write_a: assert property (done_write(spct_pkg::OFS_LOC) |=>
      {o_serial_clock_location, o_select_location, o_transmit_location} ==
      {$past(i_avs_writedata[29:24]), $past(i_avs_writedata[21:16]), $past(i_avs_writedata[13:8])})
      else $error("pin location wrong after write");
   match_sets_flag_a: assert property (o_match_event != 3'h0 |=>
      (o_match_flag & $past(o_match_event)) == $past(o_match_event))
      else $error("match flag not set after match event");
   match_when_running_a: assert property (o_match_event != 3'h0 |-> o_timer_running)
      else $error("match event while timer stopped");
   fixed_span_a: assert property (i_timing_code < 3'h4 |-> o_timing_span == {6'h00, i_timing_code})
      else $error("fixed timing span wrong");
   seven_span_a: assert property (i_timing_code == 3'h4 |-> o_timing_span == spct_pkg::SPAN_FIX4)
      else $error("seven baud span wrong");
   reset_state_a: assert property ($rose(i_resetn) |-> o_match_flag == 3'h0 && !o_timer_running &&
      {o_request_pin_enable, o_clear_pin_enable, o_serial_clock_pin_enable, o_select_pin_enable} == 4'h0 &&
      {o_serial_clock_location, o_select_location, o_transmit_location, o_receive_location} == 24'h000000)
      else $error("outputs not at reset values");
endmodule
bind spct_timer_route spct_timer_route_properties #(.DIV_W(DIV_W)) u_props (.*);

//--- bench/testbench.sv
// self-checking bench for the compare timer and routing block
`timescale 1ns/1ps
module testbench;
   logic i_sys_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] i_avs_address = 8'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0000_0000;
   logic [3:0] i_avs_byteenable = 4'hF;
   logic i_tx_frame_end = 1'b0;
   logic i_tx_done = 1'b0;
   logic i_tx_begin = 1'b0;
   logic i_rx_frame_end = 1'b0;
   logic i_rx_line = 1'b1;
   logic [2:0] i_timing_code = 3'h0;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest, o_timer_running;
   logic [8:0] o_timing_span;
   logic [2:0] o_match_event, o_match_flag;
   logic o_receive_pin_enable, o_transmit_pin_enable, o_select_pin_enable;
   logic o_serial_clock_pin_enable, o_clear_pin_enable, o_request_pin_enable;
   logic [5:0] o_receive_location, o_transmit_location, o_select_location, o_serial_clock_location;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   int vals[4] = '{2, 1, 5, 0};
   int spans[8] = '{0, 1, 2, 3, 7, 256, 1, 200};
   wire [31:0] pen = {26'h0, o_request_pin_enable, o_clear_pin_enable, o_serial_clock_pin_enable,
      o_select_pin_enable, o_transmit_pin_enable, o_receive_pin_enable};
   wire [31:0] locs = {2'h0, o_serial_clock_location, 2'h0, o_select_location, 2'h0, o_transmit_location,
      2'h0, o_receive_location};
   spct_timer_route #(.DIV_W(16)) DUT (.*);
   always #4 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (fail_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge i_sys_clk);
      i_avs_address <= a;
      i_avs_read <= rd;
      i_avs_write <= !rd;
      i_avs_writedata <= d;
      do @(posedge i_sys_clk);
      while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, q);
   endtask
   task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b1, a, 32'h0000_0000, q);
      check(name, exp, q);
   endtask
   function automatic logic [31:0] cfg(input logic rs, input logic [2:0] sp, input logic [2:0] st, input int v);
      return {7'h00, rs, 1'b0, sp, 1'b0, st, 8'h00, 8'(v)};
   endfunction
   // fire a start source (0 fires none) and count cycles up to the channel's match event
   task automatic run(input int ch, input logic [2:0] src, input int exp_n);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_tx_frame_end <= (src == 3'h1);
      i_tx_done <= (src == 3'h2);
      i_rx_frame_end <= (src == 3'h4);
      if (src == 3'h3) i_rx_line <= 1'b0;
      do begin
         @(posedge i_sys_clk);
         {i_tx_frame_end, i_tx_done, i_rx_frame_end} <= 3'h0;
         #1;
         n++;
      end while (o_match_event[ch] !== 1'b1 && n < 300);
      check("match delay", exp_n, n);
   endtask
   task automatic rx_stop(input logic [2:0] sp, input logic level);
      wr(spct_pkg::OFS_CMP2, cfg(1'b0, sp, 3'h1, 200));
      @(posedge i_sys_clk);
      i_tx_frame_end <= 1'b1;
      @(posedge i_sys_clk);
      i_tx_frame_end <= 1'b0;
      i_rx_line <= level;
      #1;
      check("timer running", 32'h1, o_timer_running);
      repeat (4) @(posedge i_sys_clk);
      #1;
      check("timer running", 32'h0, o_timer_running);
   endtask
   initial begin
      repeat (3) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      for (int a = 8'h68; a <= 8'h7C; a += 4) rd_check("reset value", 8'(a), 32'h0);
      check("pin enables", 32'h0, pen);
      check("locations", 32'h0, locs);
      wr(spct_pkg::OFS_BAUD, 32'h0);
      for (int b = 0; b < 6; b++) begin
         wr(spct_pkg::OFS_PEN, 32'h1 << b);
         check("pin enables", 32'h1 << b, pen);
      end
      wr(spct_pkg::OFS_PEN, 32'hFFFF_FFFF);
      rd_check("pin enable readback", spct_pkg::OFS_PEN, 32'h0000_003F);
      wr(spct_pkg::OFS_LOC, 32'h1F15_0A1F);
      check("locations", 32'h1F15_0A1F, locs);
      wr(spct_pkg::OFS_LOC, 32'hFFFF_FFFF);
      rd_check("location readback", spct_pkg::OFS_LOC, 32'h3F3F_3F3F);
      wr(spct_pkg::OFS_CMP2, 32'hFFFF_FFFF);
      rd_check("config readback", spct_pkg::OFS_CMP2, 32'h0177_00FF);
      for (int k = 0; k < 4; k++) begin
         wr(8'h68 + 8'(4 * (k % 3)), cfg(1'b0, 3'h0, 3'(k + 1), vals[k]));
         run(k % 3, 3'(k + 1), (vals[k] == 0 ? 256 : vals[k]) + (k == 2 ? 2 : 0));
         @(posedge i_sys_clk);
         i_rx_line <= 1'b1;
         #1;
         check("match flag", 32'h1 << (k % 3), {29'h0, o_match_flag});
         check("timer running", 32'h0, o_timer_running);
         wr(spct_pkg::OFS_STAT, 32'h7);
         check("match flag", 32'h0, {29'h0, o_match_flag});
      end
      wr(spct_pkg::OFS_CMP0, cfg(1'b1, 3'h1, 3'h1, 3));
      run(0, 3'h1, 3);
      run(0, 3'h0, 2);
      @(posedge i_sys_clk);
      i_tx_begin <= 1'b1;
      @(posedge i_sys_clk);
      i_tx_begin <= 1'b0;
      #1;
      check("timer running", 32'h0, o_timer_running);
      wr(spct_pkg::OFS_CMP0, cfg(1'b0, 3'h0, 3'h0, 0));
      wr(spct_pkg::OFS_BAUD, 32'h1);
      run(1, 3'h2, 2);
      wr(spct_pkg::OFS_BAUD, 32'h0);
      rx_stop(3'h2, 1'b0);
      rx_stop(3'h3, 1'b1);
      wr(spct_pkg::OFS_CTRL, 32'h1);
      rx_stop(3'h3, 1'b0);
      for (int c = 0; c < 8; c++) begin
         @(posedge i_sys_clk);
         i_timing_code <= 3'(c);
         #1;
         check("timing span", spans[c], {23'h0, o_timing_span});
      end
      print_verdict();
   end
endmodule

//--- core/spct_baud_div.sv
// divider that makes the one-cycle baud-time enable
`timescale 1ns/1ps
module spct_baud_div #(
   parameter int DIV_W = 16
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // divisor, tick every divisor+1 cycles
   input wire logic [DIV_W-1:0] i_divisor,
   // timer start, aligns the first baud-time to it
   input wire logic i_restart,
   // baud-time enable
   output logic o_tick
);
   logic [DIV_W-1:0] count;
   wire logic at_end = (count >= i_divisor);
   assign o_tick = at_end;
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         count <= '0;
      end else if (i_restart || at_end) begin
         count <= '0;
      end else begin
         count <= count + {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end
endmodule

//--- core/spct_comparator.sv
// one comparator channel: arming, match and disarming
`timescale 1ns/1ps
module spct_comparator (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // channel link
   spct_cmp_if.chan cmp
);
   spct_pkg::spct_cmp_state_e state;
   spct_pkg::spct_cmp_state_e next_state;
   wire logic [8:0] span = (cmp.value == 8'h00) ? spct_pkg::SPAN_OF_ZERO : {1'b0, cmp.value};
   wire logic start_hit = (cmp.start_src == spct_pkg::START_TXEND && cmp.ev_tx_end)
                        || (cmp.start_src == spct_pkg::START_TXDONE && cmp.ev_tx_done)
                        || (cmp.start_src == spct_pkg::START_RX_GOES_ACTIVE && cmp.ev_rx_act)
                        || (cmp.start_src == spct_pkg::START_RXEND && cmp.ev_rx_end);
   wire logic is_match = (state == spct_pkg::CMP_ARMED) && cmp.tick && (cmp.timer_next == span);
   wire logic stop_hit = (cmp.stop_src == spct_pkg::STOP_MATCH && is_match)
                       || (cmp.stop_src == spct_pkg::STOP_TXBEGIN && cmp.ev_tx_begin)
                       || (cmp.stop_src == spct_pkg::STOP_RX_GOES_ACTIVE && cmp.ev_rx_act)
                       || (cmp.stop_src == spct_pkg::STOP_RXINACT && cmp.ev_rx_inact);
   assign cmp.match = is_match;
   assign cmp.started = start_hit;
   assign cmp.armed = (state == spct_pkg::CMP_ARMED);
   always_comb begin
      next_state = state;
      case (state)
         spct_pkg::CMP_IDLE: begin
            if (start_hit) begin
               next_state = spct_pkg::CMP_ARMED;
            end
         end
         spct_pkg::CMP_ARMED: begin
            if (cmp.start_src == spct_pkg::START_OFF) begin
               next_state = spct_pkg::CMP_IDLE;
            end else if (stop_hit && !start_hit) begin
               next_state = spct_pkg::CMP_IDLE;
            end
         end
         default: begin
            next_state = spct_pkg::CMP_IDLE;
         end
      endcase
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         state <= spct_pkg::CMP_IDLE;
      end else begin
         state <= next_state;
      end
   end
endmodule

//--- core/spct_timer_route.sv
// compare timer channels and pin routing registers of a serial port
// What this block does
// - start field: 0 keeps disabled; 1-4 arm at tx end, tx done, rx active, rx end.
// - stop field: 0 own match, 1 tx begin, 2 rx active, 3 rx inactive.
// - timer equal to compare value gives that channel's event and sets its flag.
// - compare value counts baud-times; zero means 256 baud-times.
// - receive line counts active when low by default.
// - all comparator fields reset to zero.
// - pin enable bit 1 transmit pin, bit 0 receive pin, reset off.
// - pin enable bit 3 serial clock pin, bit 2 select pin, reset off.
// - pin enable bit 5 request pin, bit 4 clear pin, reset off.
// - clock, select, transmit locations are 6-bit fields, reset to zero.
// - channel zero stop code 1 disarms at transmit start.
// - timing codes 5 to 7 use channel 0, 1, 2 compare spans.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module spct_timer_route #(
   parameter int DIV_W = 16
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // avalon-mm slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // serial engine frame events, one-cycle pulses
   input wire logic i_tx_frame_end,
   input wire logic i_tx_done,
   input wire logic i_tx_begin,
   input wire logic i_rx_frame_end,
   // receive line pin
   input wire logic i_rx_line,
   // timing code lookup for the serial engine
   input wire logic [2:0] i_timing_code,
   output logic [8:0] o_timing_span,
   // comparator results
   output logic [2:0] o_match_event,
   output logic [2:0] o_match_flag,
   output logic o_timer_running,
   // pin enables
   output logic o_receive_pin_enable,
   output logic o_transmit_pin_enable,
   output logic o_select_pin_enable,
   output logic o_serial_clock_pin_enable,
   output logic o_clear_pin_enable,
   output logic o_request_pin_enable,
   // pin locations
   output logic [5:0] o_receive_location,
   output logic [5:0] o_transmit_location,
   output logic [5:0] o_select_location,
   output logic [5:0] o_serial_clock_location
);
   logic [31:0] cmp_cfg [spct_pkg::NUM_CMP];
   logic [31:0] pin_enable_mask;
   logic [31:0] pin_location_select_a;
   logic [31:0] baud_divisor;
   logic [31:0] port_control;
   logic [2:0] match_flag;
   logic [8:0] timer;
   logic rx_meta;
   logic rx_sync;
   logic rx_prev;
   logic bus_ack;
   logic [31:0] read_word;
   logic baud_tick;
   logic [2:0] armed_vec;
   logic [2:0] match_vec;
   logic [2:0] start_vec;
   logic [2:0] restart_vec;
   logic [8:0] span_vec [spct_pkg::NUM_CMP];

   // bus decode: one wait cycle, answer on the second
   wire logic bus_req = i_avs_read || i_avs_write;
   wire logic wr_take = i_avs_write && bus_ack;
   wire logic rd_take = i_avs_read && !bus_ack;
   wire logic [31:0] be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                                {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   wire logic sel_cmp0 = (i_avs_address == spct_pkg::OFS_CMP0);
   wire logic sel_cmp1 = (i_avs_address == spct_pkg::OFS_CMP1);
   wire logic sel_cmp2 = (i_avs_address == spct_pkg::OFS_CMP2);
   wire logic sel_pen = (i_avs_address == spct_pkg::OFS_PEN);
   wire logic sel_loc = (i_avs_address == spct_pkg::OFS_LOC);
   wire logic sel_baud = (i_avs_address == spct_pkg::OFS_BAUD);
   wire logic sel_stat = (i_avs_address == spct_pkg::OFS_STAT);
   wire logic sel_ctrl = (i_avs_address == spct_pkg::OFS_CTRL);
   wire logic [2:0] sel_cmp = {sel_cmp2, sel_cmp1, sel_cmp0};
   assign o_avs_waitrequest = bus_req && !bus_ack;

   // receive line: active low unless inverted
   wire logic rx_invert = port_control[spct_pkg::CTRL_RXINV_BIT];
   wire logic rx_active_now = rx_invert ? rx_sync : !rx_sync;
   wire logic rx_active_prev = rx_invert ? rx_prev : !rx_prev;
   wire logic ev_rx_act = rx_active_now && !rx_active_prev;
   wire logic ev_rx_inact = !rx_active_now && rx_active_prev;

   // shared timer
   wire logic any_armed = |armed_vec;
   wire logic any_start = |start_vec;
   wire logic any_restart = |(match_vec & restart_vec);
   wire logic [8:0] timer_next = timer + 9'h001;
   wire logic [2:0] flag_clear = (wr_take && sel_stat && i_avs_byteenable[0])
                                 ? i_avs_writedata[spct_pkg::STAT_FLAG_LSB +: 3] : 3'h0;

   spct_baud_div #(
      .DIV_W(DIV_W)
   ) u_baud_div (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_divisor(baud_divisor[DIV_W-1:0]),
      .i_restart(any_start),
      .o_tick(baud_tick)
   );

   genvar ch;
   generate
      for (ch = 0; ch < spct_pkg::NUM_CMP; ch++) begin : g_cmp
         spct_cmp_if cif ();
         assign cif.start_src = cmp_cfg[ch][spct_pkg::CMP_START_LSB +: 3];
         assign cif.stop_src = cmp_cfg[ch][spct_pkg::CMP_STOP_LSB +: 3];
         assign cif.restart = cmp_cfg[ch][spct_pkg::CMP_RESTART_BIT];
         assign cif.value = cmp_cfg[ch][spct_pkg::CMP_VAL_LSB +: 8];
         assign cif.tick = baud_tick;
         assign cif.timer_next = timer_next;
         assign cif.ev_tx_end = i_tx_frame_end;
         assign cif.ev_tx_done = i_tx_done;
         assign cif.ev_tx_begin = i_tx_begin;
         assign cif.ev_rx_act = ev_rx_act;
         assign cif.ev_rx_inact = ev_rx_inact;
         assign cif.ev_rx_end = i_rx_frame_end;
         assign armed_vec[ch] = cif.armed;
         assign match_vec[ch] = cif.match;
         assign start_vec[ch] = cif.started;
         assign restart_vec[ch] = cif.restart;
         assign span_vec[ch] = (cif.value == 8'h00) ? spct_pkg::SPAN_OF_ZERO : {1'b0, cif.value};
         spct_comparator u_cmp (
            .i_sys_clk(i_sys_clk),
            .i_resetn(i_resetn),
            .cmp(cif)
         );
         always_ff @(posedge i_sys_clk) begin
            if (!i_resetn) begin
               cmp_cfg[ch] <= spct_pkg::REG_RST;
            end else if (wr_take && sel_cmp[ch]) begin
               cmp_cfg[ch] <= ((cmp_cfg[ch] & ~be_mask) | (i_avs_writedata & be_mask)) & spct_pkg::CMP_MASK;
            end
         end
         always_ff @(posedge i_sys_clk) begin
            if (!i_resetn) begin
               match_flag[ch] <= 1'b0;
            end else if (match_vec[ch]) begin
               match_flag[ch] <= 1'b1;
            end else if (flag_clear[ch]) begin
               match_flag[ch] <= 1'b0;
            end
         end
      end
   endgenerate

   // timing code lookup
   always_comb begin
      case (i_timing_code)
         3'h0: o_timing_span = spct_pkg::SPAN_FIX0;
         3'h1: o_timing_span = spct_pkg::SPAN_FIX1;
         3'h2: o_timing_span = spct_pkg::SPAN_FIX2;
         3'h3: o_timing_span = spct_pkg::SPAN_FIX3;
         3'h4: o_timing_span = spct_pkg::SPAN_FIX4;
         3'h5: o_timing_span = span_vec[0];
         3'h6: o_timing_span = span_vec[1];
         3'h7: o_timing_span = span_vec[2];
         default: o_timing_span = spct_pkg::SPAN_FIX0;
      endcase
   end

   // read mux
   always_comb begin
      read_word = 32'h0000_0000;
      case (1'b1)
         sel_cmp0: read_word = cmp_cfg[0];
         sel_cmp1: read_word = cmp_cfg[1];
         sel_cmp2: read_word = cmp_cfg[2];
         sel_pen: read_word = pin_enable_mask;
         sel_loc: read_word = pin_location_select_a;
         sel_baud: read_word = baud_divisor;
         sel_ctrl: read_word = port_control;
         sel_stat: begin
            read_word[spct_pkg::STAT_FLAG_LSB +: 3] = match_flag;
            read_word[spct_pkg::STAT_EN_LSB +: 3] = armed_vec;
            read_word[spct_pkg::STAT_TIMER_LSB +: 9] = timer;
         end
         default: read_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         bus_ack <= 1'b0;
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         bus_ack <= bus_req && !bus_ack;
         if (rd_take) begin
            o_avs_readdata <= read_word;
         end
      end
   end

   // routing registers, reserved bits masked off
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         pin_enable_mask <= spct_pkg::REG_RST;
         pin_location_select_a <= spct_pkg::REG_RST;
         baud_divisor <= spct_pkg::REG_RST;
         port_control <= spct_pkg::REG_RST;
      end else if (wr_take) begin
         if (sel_pen) begin
            pin_enable_mask <= ((pin_enable_mask & ~be_mask) | (i_avs_writedata & be_mask)) & spct_pkg::PEN_MASK;
         end
         if (sel_loc) begin
            pin_location_select_a <= ((pin_location_select_a & ~be_mask) | (i_avs_writedata & be_mask))
                                     & spct_pkg::LOC_MASK;
         end
         if (sel_baud) begin
            baud_divisor <= ((baud_divisor & ~be_mask) | (i_avs_writedata & be_mask)) & spct_pkg::BAUD_MASK;
         end
         if (sel_ctrl) begin
            port_control <= ((port_control & ~be_mask) | (i_avs_writedata & be_mask)) & spct_pkg::CTRL_MASK;
         end
      end
   end

   // receive line synchroniser and edge history
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= i_rx_line;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end

   // shared timer: cleared on start or restarting match, counts baud-times while armed
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         timer <= 9'h000;
      end else if (any_start) begin
         timer <= 9'h000;
      end else if (any_restart) begin
         timer <= 9'h000;
      end else if (any_armed && baud_tick) begin
         timer <= timer_next;
      end
   end

   assign o_match_event = match_vec;
   assign o_match_flag = match_flag;
   assign o_timer_running = any_armed;
   assign o_receive_pin_enable = pin_enable_mask[spct_pkg::PEN_RX_BIT];
   assign o_transmit_pin_enable = pin_enable_mask[spct_pkg::PEN_TX_BIT];
   assign o_select_pin_enable = pin_enable_mask[spct_pkg::PEN_CS_BIT];
   assign o_serial_clock_pin_enable = pin_enable_mask[spct_pkg::PEN_CLK_BIT];
   assign o_clear_pin_enable = pin_enable_mask[spct_pkg::PEN_CTS_BIT];
   assign o_request_pin_enable = pin_enable_mask[spct_pkg::PEN_RTS_BIT];
   assign o_receive_location = pin_location_select_a[spct_pkg::LOC_RX_LSB +: 6];
   assign o_transmit_location = pin_location_select_a[spct_pkg::LOC_TX_LSB +: 6];
   assign o_select_location = pin_location_select_a[spct_pkg::LOC_CS_LSB +: 6];
   assign o_serial_clock_location = pin_location_select_a[spct_pkg::LOC_CLK_LSB +: 6];
endmodule

//--- include/spct_cmp_if.sv
// configuration, events and match results of one comparator channel
`timescale 1ns/1ps
interface spct_cmp_if;
   logic [2:0] start_src;
   logic [2:0] stop_src;
   logic restart;
   logic [7:0] value;
   logic tick;
   logic [8:0] timer_next;
   logic ev_tx_end;
   logic ev_tx_done;
   logic ev_tx_begin;
   logic ev_rx_act;
   logic ev_rx_inact;
   logic ev_rx_end;
   logic started;
   logic armed;
   logic match;
   modport ctrl (output start_src, stop_src, restart, value, tick, timer_next, ev_tx_end, ev_tx_done,
                 ev_tx_begin, ev_rx_act, ev_rx_inact, ev_rx_end, input started, armed, match);
   modport chan (input start_src, stop_src, restart, value, tick, timer_next, ev_tx_end, ev_tx_done,
                 ev_tx_begin, ev_rx_act, ev_rx_inact, ev_rx_end, output started, armed, match);
endinterface

//--- include/spct_pkg.sv
// constants and types shared by the compare timer and routing block
package spct_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CMP0 = 8'h68;
   localparam logic [7:0] OFS_CMP1 = 8'h6C;
   localparam logic [7:0] OFS_CMP2 = 8'h70;
   localparam logic [7:0] OFS_PEN = 8'h74;
   localparam logic [7:0] OFS_LOC = 8'h78;
   localparam logic [7:0] OFS_BAUD = 8'h80;
   localparam logic [7:0] OFS_STAT = 8'h84;
   localparam logic [7:0] OFS_CTRL = 8'h88;
   // reset value of every register
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   // writable bits of each register, the rest read zero
   localparam logic [31:0] CMP_MASK = 32'h0177_00FF;
   localparam logic [31:0] PEN_MASK = 32'h0000_003F;
   localparam logic [31:0] LOC_MASK = 32'h3F3F_3F3F;
   localparam logic [31:0] BAUD_MASK = 32'h0000_FFFF;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
   // comparator config fields
   localparam int CMP_VAL_LSB = 0;
   localparam int CMP_START_LSB = 16;
   localparam int CMP_STOP_LSB = 20;
   localparam int CMP_RESTART_BIT = 24;
   // pin enable bits
   localparam int PEN_RX_BIT = 0;
   localparam int PEN_TX_BIT = 1;
   localparam int PEN_CS_BIT = 2;
   localparam int PEN_CLK_BIT = 3;
   localparam int PEN_CTS_BIT = 4;
   localparam int PEN_RTS_BIT = 5;
   // location fields
   localparam int LOC_RX_LSB = 0;
   localparam int LOC_TX_LSB = 8;
   localparam int LOC_CS_LSB = 16;
   localparam int LOC_CLK_LSB = 24;
   // status fields
   localparam int STAT_FLAG_LSB = 0;
   localparam int STAT_EN_LSB = 8;
   localparam int STAT_TIMER_LSB = 16;
   // control bits
   localparam int CTRL_RXINV_BIT = 0;
   // start and stop source codes
   localparam logic [2:0] START_OFF = 3'h0;
   localparam logic [2:0] START_TXEND = 3'h1;
   localparam logic [2:0] START_TXDONE = 3'h2;
   localparam logic [2:0] START_RX_GOES_ACTIVE = 3'h3;
   localparam logic [2:0] START_RXEND = 3'h4;
   localparam logic [2:0] STOP_MATCH = 3'h0;
   localparam logic [2:0] STOP_TXBEGIN = 3'h1;
   localparam logic [2:0] STOP_RX_GOES_ACTIVE = 3'h2;
   localparam logic [2:0] STOP_RXINACT = 3'h3;
   // spans in baud-times
   localparam logic [8:0] SPAN_OF_ZERO = 9'h100;
   localparam logic [8:0] SPAN_FIX0 = 9'h000;
   localparam logic [8:0] SPAN_FIX1 = 9'h001;
   localparam logic [8:0] SPAN_FIX2 = 9'h002;
   localparam logic [8:0] SPAN_FIX3 = 9'h003;
   localparam logic [8:0] SPAN_FIX4 = 9'h007;
   localparam int NUM_CMP = 3;
   typedef enum logic {CMP_IDLE, CMP_ARMED} spct_cmp_state_e;
endpackage
